// ==== hw/atwrp_readout.sv ====
// Functional notes
// RULE1: data output held low for the whole conversion, as busy.
// RULE2: after conversion each serial clock fall presents next bit, MSB first.
// RULE3: power-fail flag pulled low while sense input is below reference.
// RULE4: channel select inputs captured on the fall that starts conversion.
// RULE5: code high,low: 00 input one, 01 two, 10 three, 11 four.
// RULE6: serial clock driven low wakes device and starts a conversion.
// RULE7: up to six further falls in window each drop one resolution bit.
// RULE8: bits shifted equal full width minus reductions; sleep after last.
`timescale 1ns/1ns
`default_nettype none
`include "atwrp_cfg.svh"

module atwrp_readout #(
    parameter int FULL_BITS  = `ATWRP_FULL_BITS,
    parameter int MAX_REDUCE = `ATWRP_MAX_REDUCE,
    parameter int WINDOW_CYC = `ATWRP_WINDOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        serial_clk_in,
    input  wire logic        channel_select_high,
    input  wire logic        channel_select_low,
    input  wire logic        power_fail_sense_below,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    output logic             serial_data_out,
    output logic             power_fail_flag_out,
    output logic             power_fail_flag_oe,
    output logic             conv_start,
    output logic [1:0]       conv_channel,
    output logic [2:0]       conv_reduce,
    output logic             busy
);
    // two-flop synchronisers for pins
    logic [1:0] sclk_sync;
    logic [1:0] csh_sync;
    logic [1:0] csl_sync;
    logic [1:0] pfs_sync;
    logic       sclk_prev;
    logic       sclk_fall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_sync <= 2'h3;
            csh_sync  <= 2'h0;
            csl_sync  <= 2'h0;
            pfs_sync  <= 2'h0;
            sclk_prev <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], serial_clk_in};
            csh_sync  <= {csh_sync[0], channel_select_high};
            csl_sync  <= {csl_sync[0], channel_select_low};
            pfs_sync  <= {pfs_sync[0], power_fail_sense_below};
            sclk_prev <= sclk_sync[1];
        end
    end

    // falling edge of the synchronised serial clock
    assign sclk_fall = sclk_prev & ~sclk_sync[1];

    atwrp_pkg::atwrp_state_t state;
    atwrp_pkg::atwrp_state_t next_state;
    logic [15:0] win_cnt;
    logic [15:0] next_win_cnt;
    logic [2:0]  reduce;
    logic [2:0]  next_reduce;
    logic [4:0]  bits_left;
    logic [4:0]  next_bits_left;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic        sdo;
    logic        next_sdo;
    logic [1:0]  chan;
    logic [1:0]  next_chan;
    logic        start;
    logic        next_start;

    // conversion sequencer: next values
    always_comb begin
        next_state     = state;
        next_win_cnt   = win_cnt;
        next_reduce    = reduce;
        next_bits_left = bits_left;
        next_shreg     = shreg;
        next_sdo       = sdo;
        next_chan      = chan;
        next_start     = 1'b0;
        case (state)
            atwrp_pkg::ATWRP_SLEEP: begin
                next_sdo = 1'b1;
                if (sclk_fall) begin // [RULE6]
                    next_chan = {csh_sync[1], csl_sync[1]}; // [RULE4] [RULE5]
                    next_reduce  = 3'h0;
                    next_win_cnt = 16'h0000;
                    next_sdo     = 1'b0; // [RULE1]
                    next_state   = atwrp_pkg::ATWRP_REDUCE;
                end
            end
            atwrp_pkg::ATWRP_REDUCE: begin
                next_sdo     = 1'b0; // [RULE1]
                next_win_cnt = win_cnt + 16'h0001;
                if (sclk_fall && reduce < 3'(MAX_REDUCE)) begin
                    next_reduce = reduce + 3'h1; // [RULE7]
                end
                if (win_cnt >= 16'(WINDOW_CYC - 1)) begin
                    next_start = 1'b1;
                    next_state = atwrp_pkg::ATWRP_CONVERT;
                end
            end
            atwrp_pkg::ATWRP_CONVERT: begin
                next_sdo = 1'b0; // [RULE1]
                if (conv_done) begin
                    // result left aligned, unused low bits are dropped
                    next_shreg     = conv_result;
                    next_bits_left = 5'(FULL_BITS) - {2'h0, reduce}; // [RULE8]
                    next_state     = atwrp_pkg::ATWRP_SHIFT;
                end
            end
            atwrp_pkg::ATWRP_SHIFT: begin
                if (sclk_fall) begin
                    if (bits_left == 5'h00) begin
                        next_sdo   = 1'b1;
                        next_state = atwrp_pkg::ATWRP_SLEEP; // [RULE8]
                    end else begin
                        next_sdo       = shreg[15]; // [RULE2]
                        next_shreg     = {shreg[14:0], 1'b0};
                        next_bits_left = bits_left - 5'h01;
                    end
                end
            end
            default: next_state = atwrp_pkg::ATWRP_SLEEP;
        endcase
    end

    // conversion sequencer: registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= atwrp_pkg::ATWRP_SLEEP;
            win_cnt   <= 16'h0000;
            reduce    <= 3'h0;
            bits_left <= 5'h00;
            shreg     <= 16'h0000;
            sdo       <= 1'b1;
            chan      <= 2'h0;
            start     <= 1'b0;
        end else begin
            state     <= next_state;
            win_cnt   <= next_win_cnt;
            reduce    <= next_reduce;
            bits_left <= next_bits_left;
            shreg     <= next_shreg;
            sdo       <= next_sdo;
            chan      <= next_chan;
            start     <= next_start;
        end
    end

    logic pf_low;
    // open-drain flag: drive low only while sense is below reference
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pf_low <= 1'b0;
        end else begin
            pf_low <= pfs_sync[1]; // [RULE3]
        end
    end

    assign serial_data_out     = sdo;
    assign power_fail_flag_out = 1'b0;
    assign power_fail_flag_oe  = pf_low;
    assign conv_start          = start;
    assign conv_channel        = chan;
    assign conv_reduce         = reduce;
    assign busy                = (state == atwrp_pkg::ATWRP_REDUCE) ||
                                 (state == atwrp_pkg::ATWRP_CONVERT);

    // busy implies data line low
    AST_BUSY_LOW: assert property (@(posedge clk) disable iff (rst)
        busy |-> !serial_data_out) // [RULE1]
        else $error("data line not low while converting");

    // channel taken from pins on the starting edge
    AST_CHAN_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        (state == atwrp_pkg::ATWRP_SLEEP && sclk_fall) |=>
        conv_channel == $past({csh_sync[1], csl_sync[1]})) // [RULE4]
        else $error("channel code not captured at start");

    // wake on falling edge
    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        (state == atwrp_pkg::ATWRP_SLEEP && sclk_fall) |=>
        state == atwrp_pkg::ATWRP_REDUCE) // [RULE6]
        else $error("no wake on falling edge");

    // reduction count never exceeds limit
    AST_REDUCE_MAX: assert property (@(posedge clk) disable iff (rst)
        conv_reduce <= 3'(MAX_REDUCE)) // [RULE7]
        else $error("reduction count above limit");

    // a fall inside the window under limit adds one
    AST_REDUCE_STEP: assert property (@(posedge clk) disable iff (rst)
        (state == atwrp_pkg::ATWRP_REDUCE && sclk_fall &&
         conv_reduce < 3'(MAX_REDUCE)) |=>
        conv_reduce == $past(conv_reduce) + 3'h1) // [RULE7]
        else $error("reduction edge not counted");

    // bit count loaded from resolution
    AST_BITCOUNT: assert property (@(posedge clk) disable iff (rst)
        (state == atwrp_pkg::ATWRP_CONVERT && conv_done) |=>
        bits_left == 5'(FULL_BITS) - {2'h0, conv_reduce}) // [RULE8]
        else $error("shift count wrong");

    // shifted bit is the msb of the register
    sequence seq_shift_fall;
        state == atwrp_pkg::ATWRP_SHIFT && sclk_fall && bits_left != 5'h00;
    endsequence
    AST_MSB_FIRST: assert property (@(posedge clk) disable iff (rst)
        seq_shift_fall |=> serial_data_out == $past(shreg[15])) // [RULE2]
        else $error("wrong bit shifted out");

    // power-fail pull starts one cycle after synchronised sense rises
    AST_PF_FLAG: assert property (@(posedge clk) disable iff (rst)
        $rose(pfs_sync[1]) |=> power_fail_flag_oe) // [RULE3]
        else $error("power-fail flag not pulled low");

endmodule // atwrp_readout
`default_nettype wire

// ==== inc/atwrp_cfg.svh ====
`ifndef ATWRP_CFG_SVH
`define ATWRP_CFG_SVH
// full result width in bits
`define ATWRP_FULL_BITS      16
// most reduction edges that count
`define ATWRP_MAX_REDUCE     6
// reduction window in ns (plain default)
`define ATWRP_WINDOW_NS      1000
// clock period in ns
`define ATWRP_CLK_NS         4
// window length in clk cycles, rounded down
`define ATWRP_WINDOW_CYC     (`ATWRP_WINDOW_NS / `ATWRP_CLK_NS)
// channel codes
`define ATWRP_CH_IN1         2'h0
`define ATWRP_CH_IN2         2'h1
`define ATWRP_CH_IN3         2'h2
`define ATWRP_CH_IN4         2'h3
`endif

// ==== inc/atwrp_pkg.sv ====
package atwrp_pkg;
    typedef enum logic [1:0] {
        ATWRP_SLEEP,
        ATWRP_REDUCE,
        ATWRP_CONVERT,
        ATWRP_SHIFT
    } atwrp_state_t;
endpackage

// ==== verification/atwrp_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module atwrp_host_model (
    input  wire logic clk,
    input  wire logic sdata,
    output var  logic sclk,
    output var  logic sel_hi,
    output var  logic sel_lo
);
    // serial clock idles high between frames
    initial begin
        sclk   = 1'b1;
        sel_hi = 1'b0;
        sel_lo = 1'b0;
    end

    // channel code placed on the select pins ahead of the start fall
    task automatic sel(input logic [1:0] c);
        @(posedge clk);
        {sel_hi, sel_lo} <= c;
    endtask

    // one low phase of 8 clk then a high phase of 8 clk, 9 when called back to back (68 ns period)
    // data is read late in the low phase, well after it has settled
    task automatic clock_bit(output logic b);
        @(posedge clk);
        sclk <= 1'b0;
        repeat (8) @(posedge clk);
        b = sdata;
        sclk <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule // atwrp_host_model

`default_nettype wire

// ==== verification/tb_adc_two_wire_readout_port.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_adc_two_wire_readout_port;
    logic        clk, rst, pf_below, done, b;
    logic        sdo, pf_out, pf_oe, start, busy;
    logic [15:0] result;
    logic [1:0]  chan;
    logic [2:0]  red;
    wire  logic  sclk, sel_hi, sel_lo;
    int          errors, checks, r, n;
    bit          q[$];

    // system clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    atwrp_host_model host (.clk(clk), .sdata(sdo), .sclk(sclk),
        .sel_hi(sel_hi), .sel_lo(sel_lo));

    atwrp_readout #(.WINDOW_CYC(200)) uut (
        .clk(clk), .rst(rst), .serial_clk_in(sclk),
        .channel_select_high(sel_hi), .channel_select_low(sel_lo),
        .power_fail_sense_below(pf_below), .conv_done(done),
        .conv_result(result), .serial_data_out(sdo),
        .power_fail_flag_out(pf_out), .power_fail_flag_oe(pf_oe),
        .conv_start(start), .conv_channel(chan), .conv_reduce(red),
        .busy(busy));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected 11 us of traffic
    initial begin
        #100000;
        errors++;
        results();
    end

    // main sequence: six frames, 0 to 10 reduction falls in steps of two (count capped at 6), all channel codes
    initial begin
        rst = 1'b1;
        pf_below = 1'b0;
        done = 1'b0;
        result = 16'h0000;
        void'($urandom(32'h07360B54));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(sdo, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            r = i * 2;
            pf_below <= 1'($urandom);
            host.sel(2'(i));
            host.clock_bit(b);
            check(b, 16'h0000);
            check(busy, 16'h0001);
            host.sel(2'($urandom));
            check(chan, 16'(i % 4));
            check(pf_oe, pf_below);
            check(pf_out, 16'h0000);
            repeat (r) host.clock_bit(b);
            n = 0;
            while (start !== 1'b1 && n < 300) begin
                @(posedge clk);
                #1;
                n++;
            end
            check(start, 16'h0001);
            check(red, 16'(r > 6 ? 6 : r));
            // a fall while converting is ignored, line stays low
            host.clock_bit(b);
            check(b, 16'h0000);
            @(posedge clk);
            result <= 16'($urandom);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            for (int k = 0; k < 16 - (r > 6 ? 6 : r); k++) begin
                q.push_back(result[15 - k]);
            end
            while (q.size() > 0) begin
                host.clock_bit(b);
                check(b, q.pop_front());
            end
            host.clock_bit(b);
            check(b, 16'h0001);
            check(busy, 16'h0000);
        end
        results();
    end
endmodule // tb_adc_two_wire_readout_port

`default_nettype wire
